//--- smx_config_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module smx_config_regs
	import smx_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire smx_pins_s cmd_pins_in,
	input wire logic banks_idle_in,
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [7:0] axi_awaddr_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [7:0] axi_araddr_in,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	output smx_cfg_s cfg_out,
	output logic drive_half_out,
	output logic refresh_pulse_out,
	output logic refresh_bank_out,
	output logic [10:0] refresh_row_out
);
	typedef struct packed
	{
		smx_pins_s sync1;
		smx_pins_s sync2;
		logic [11:0] mode_value;
		logic [11:0] ext_value;
		logic [1:0] guard;
		logic sref_en;
		logic [ERR_W-1:0] err;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} smx_top_state_s;
	smx_top_state_s q;
	smx_top_state_s next_q;
	logic ld_any;
	logic ld_ext;
	logic ld_mode;
	logic cmd_any;
	logic rsvd_blen;
	logic rsvd_lat;
	logic rsvd_wmode;
	logic sr_bank;
	logic [10:0] sr_row;
	// ************************************************************
	// command decode on the synchronised pins
	// ************************************************************
	// only sync2 is looked at; sync1 may be metastable
	assign ld_any = smx_is_load(q.sync2);
	assign ld_ext = ld_any && q.sync2.addr[EXT_SEL_BIT];
	assign ld_mode = ld_any && !q.sync2.addr[EXT_SEL_BIT];
	assign cmd_any = smx_is_command(q.sync2);
	assign axi_awready_out = !q.aw_held && !q.bvalid;
	assign axi_wready_out = !q.w_held && !q.bvalid;
	assign axi_arready_out = !q.rvalid;
	// ************************************************************
	// state update
	// ************************************************************
	always_comb
	begin
		logic [ERR_W-1:0] err_set;
		logic [ERR_W-1:0] err_clr;
		err_set = '0;
		err_clr = '0;
		next_q = q;
		next_q.sync1 = cmd_pins_in;
		next_q.sync2 = q.sync1;
		if (ld_ext)
			next_q.ext_value = q.sync2.addr;
		if (ld_mode)
			next_q.mode_value = q.sync2.addr;
		if (ld_any)
			next_q.guard = LOAD_GUARD_CYCLES - 2'h1;
		else if (q.guard != 2'h0)
			next_q.guard = q.guard - 2'h1;
		err_set[ERR_WMODE] = rsvd_wmode;
		err_set[ERR_BLEN] = rsvd_blen;
		err_set[ERR_LAT] = rsvd_lat;
		err_set[ERR_EXTZ] = ld_ext && q.sync2.addr[EXT_ZERO_LSB +: 5] != 5'h00;
		err_set[ERR_BUSY] = ld_any && !banks_idle_in;
		err_set[ERR_SOON] = cmd_any && q.guard != 2'h0;
		err_set[ERR_COVER] = ld_ext && q.sync2.addr[COVER_LSB +: 3] > COVER_QUARTER;
		// write channel: address and data may come in either order
		if (axi_awvalid_in && axi_awready_out)
		begin
			next_q.aw_held = 1'b1;
			next_q.aw_addr = axi_awaddr_in;
		end
		if (axi_wvalid_in && axi_wready_out)
		begin
			next_q.w_held = 1'b1;
			next_q.w_data = axi_wdata_in;
			next_q.w_strb = axi_wstrb_in;
		end
		if (q.aw_held && q.w_held && !q.bvalid)
		begin
			next_q.aw_held = 1'b0;
			next_q.w_held = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = RESP_OKAY;
			if (q.aw_addr == REG_CTRL)
			begin
				if (q.w_strb[0])
					next_q.sref_en = q.w_data[CTRL_SREF_BIT];
			end
			else if (q.aw_addr == REG_ERR)
			begin
				if (q.w_strb[0])
					err_clr = q.w_data[ERR_W-1:0];
			end
			else if (q.aw_addr == REG_MODE || q.aw_addr == REG_EXT || q.aw_addr == REG_REFRESH)
				next_q.bresp = RESP_OKAY;
			else
				next_q.bresp = RESP_SLVERR;
		end
		else if (q.bvalid && axi_bready_in)
			next_q.bvalid = 1'b0;
		// a flag raised in the same cycle as its clear survives
		next_q.err = (q.err & ~err_clr) | err_set;
		// read channel
		if (axi_arvalid_in && axi_arready_out)
		begin
			next_q.rvalid = 1'b1;
			next_q.rresp = RESP_OKAY;
			if (axi_araddr_in == REG_MODE)
				next_q.rdata = {20'h00000, q.mode_value};
			else if (axi_araddr_in == REG_EXT)
				next_q.rdata = {20'h00000, q.ext_value};
			else if (axi_araddr_in == REG_CTRL)
				next_q.rdata = {31'h0, q.sref_en};
			else if (axi_araddr_in == REG_ERR)
				next_q.rdata = {25'h0, q.err};
			else if (axi_araddr_in == REG_REFRESH)
				next_q.rdata = {20'h00000, sr_bank, sr_row};
			else
			begin
				next_q.rdata = 32'h00000000;
				next_q.rresp = RESP_SLVERR;
			end
		end
		else if (q.rvalid && axi_rready_in)
			next_q.rvalid = 1'b0;
	end
	// the extended register has no reset of its own in the array; reset here stands
	// for power-up, which is the only time its defaults apply
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			q <= '{sync1: PINS_IDLE, sync2: PINS_IDLE, mode_value: MODE_RESET,
				ext_value: EXT_RESET, guard: 2'h0, sref_en: 1'b0, err: '0, aw_held: 1'b0,
				aw_addr: 8'h00, w_held: 1'b0, w_data: 32'h00000000, w_strb: 4'h0,
				bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h00000000,
				rresp: RESP_OKAY};
		end
		else
			q <= next_q;
	end
	// ************************************************************
	// decoders and self-refresh
	// ************************************************************
	smx_mode_decode u_decode
	(
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.load_in(ld_mode),
		.value_in(q.sync2.addr),
		.cfg_out(cfg_out),
		.rsvd_blen_out(rsvd_blen),
		.rsvd_lat_out(rsvd_lat),
		.rsvd_wmode_out(rsvd_wmode)
	);
	smx_self_refresh u_sref
	(
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.enable_in(q.sref_en),
		.coverage_in(q.ext_value[COVER_LSB +: 3]),
		.rate_in(q.ext_value[RATE_LSB +: 2]),
		.refresh_pulse_out(refresh_pulse_out),
		.refresh_bank_out(sr_bank),
		.refresh_row_out(sr_row)
	);
	assign refresh_bank_out = sr_bank;
	assign refresh_row_out = sr_row;
	assign drive_half_out = q.ext_value[DRV_BIT];
	assign axi_bvalid_out = q.bvalid;
	assign axi_bresp_out = q.bresp;
	assign axi_rvalid_out = q.rvalid;
	assign axi_rdata_out = q.rdata;
	assign axi_rresp_out = q.rresp;
	// ************************************************************
	// checks
	// ************************************************************
	AST_EXT_LOAD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_ext |=> q.ext_value == $past(q.sync2.addr))
		else $error("extended load did not store the address");
	AST_EXT_KEEP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!ld_ext |=> $stable(q.ext_value))
		else $error("extended register changed without a load");
	AST_DEFAULTS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$past(rst_in) |-> !drive_half_out && q.ext_value[4:0] == 5'h00)
		else $error("extended defaults not zero after reset");
	AST_DRIVE_HALF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_ext |=> drive_half_out == $past(q.sync2.addr[DRV_BIT]))
		else $error("drive strength does not follow bit 5");
	AST_EXT_ZERO: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_ext && q.sync2.addr[10:6] != 5'h00 |=> q.err[ERR_EXTZ])
		else $error("nonzero upper extended bits not flagged");
	AST_BUSY_LOAD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_any && !banks_idle_in |=> q.err[ERR_BUSY])
		else $error("load with busy banks not flagged");
	AST_TOO_SOON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_any ##1 cmd_any |=> q.err[ERR_SOON])
		else $error("command one cycle after load not flagged");
	AST_GUARD_OK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_any ##1 !cmd_any ##1 (cmd_any && !q.err[ERR_SOON]) |=> !q.err[ERR_SOON])
		else $error("command two cycles after load wrongly flagged");
	AST_WRITE_MODE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ld_mode && q.sync2.addr[11:7] == WM_BURST |=> !cfg_out.single_write)
		else $error("all-zero write mode did not give burst write");
endmodule

//--- smx_pkg.sv
// ************************************************************
// configuration constants for the mode and extended mode registers
// ************************************************************
// Summary of operation
// - extended load is a load command with A11 high; contents kept until reloaded.
// - extended bits 2..0 pick refresh coverage, bits 4..3 pick refresh rate.
// - extended bit 5 picks drive strength: zero full, one half.
// - drive strength bit is zero, full drive, before any extended load.
// - self-refresh refreshes only the selected region; other rows lose data.
// - coverage choices are both banks, one bank, half bank, quarter bank.
// - half-bank coverage refreshes bank 0 rows with address bit 10 zero.
// - quarter-bank coverage refreshes bank 0 rows with address bits 10, 9 zero.
// - coverage bits reset to zero, which selects full coverage.
// - uncompensated rate assumes the hottest case; compensation bits slow refresh.
// - both rate compensation bits reset to zero.
// - write-mode bits 11..7: all zero burst write, only bit 9 single write.
// - single-write mode stores one word per write regardless of burst length.
package smx_pkg;
	// ************************************************************
	// pin fields
	// ************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned EXT_SEL_BIT = 11;
	localparam int unsigned LEN_LSB = 0;
	localparam int unsigned ORDER_BIT = 3;
	localparam int unsigned LAT_LSB = 4;
	localparam int unsigned WM_LSB = 7;
	localparam int unsigned COVER_LSB = 0;
	localparam int unsigned RATE_LSB = 3;
	localparam int unsigned DRV_BIT = 5;
	localparam int unsigned EXT_ZERO_LSB = 6;
	localparam logic [2:0] LEN_1 = 3'h0;
	localparam logic [2:0] LEN_2 = 3'h1;
	localparam logic [2:0] LEN_4 = 3'h2;
	localparam logic [2:0] LEN_8 = 3'h3;
	localparam logic [2:0] LEN_FULL = 3'h7;
	localparam logic [8:0] WORDS_FULL = 9'h100;
	localparam logic [2:0] LAT_2 = 3'h2;
	localparam logic [2:0] LAT_3 = 3'h3;
	localparam logic [4:0] WM_BURST = 5'h00;
	localparam logic [4:0] WM_SINGLE = 5'h04;
	localparam logic [11:0] MODE_RESET = 12'h000;
	localparam logic [11:0] EXT_RESET = 12'h000;
	localparam logic [1:0] LAT_RESET = 2'h3;
	localparam logic [1:0] LOAD_GUARD_CYCLES = 2'h2;
	localparam logic [15:0] REFRESH_BASE_CYCLES = 16'h0200;
	typedef enum logic [2:0]
	{
		COVER_BOTH = 3'h0,
		COVER_ONE = 3'h1,
		COVER_HALF = 3'h2,
		COVER_QUARTER = 3'h3
	} smx_cover_e;
	// ************************************************************
	// register bus map
	// ************************************************************
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_EXT = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_ERR = 8'h0C;
	localparam logic [7:0] REG_REFRESH = 8'h10;
	localparam int unsigned CTRL_SREF_BIT = 0;
	localparam int unsigned ERR_W = 7;
	localparam int unsigned ERR_WMODE = 0;
	localparam int unsigned ERR_BLEN = 1;
	localparam int unsigned ERR_LAT = 2;
	localparam int unsigned ERR_EXTZ = 3;
	localparam int unsigned ERR_BUSY = 4;
	localparam int unsigned ERR_SOON = 5;
	localparam int unsigned ERR_COVER = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed
	{
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [11:0] addr;
	} smx_pins_s;
	localparam smx_pins_s PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
		addr: 12'h000};
	typedef struct packed
	{
		logic [8:0] burst_words;
		logic interleaved;
		logic [1:0] read_latency;
		logic single_write;
		logic [8:0] write_words;
	} smx_cfg_s;
	function automatic logic smx_is_load(input smx_pins_s p);
		return !p.cs_n && !p.ras_n && !p.cas_n && !p.we_n;
	endfunction
	function automatic logic smx_is_command(input smx_pins_s p);
		return !p.cs_n && !(p.ras_n && p.cas_n && p.we_n);
	endfunction
endpackage

//--- smx_mode_decode.sv
`timescale 1ns/10ps
module smx_mode_decode
	import smx_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [11:0] value_in,
	output smx_cfg_s cfg_out,
	output logic rsvd_blen_out,
	output logic rsvd_lat_out,
	output logic rsvd_wmode_out
);
	typedef struct packed
	{
		smx_cfg_s cfg;
		logic rsvd_blen;
		logic rsvd_lat;
		logic rsvd_wmode;
	} smx_dec_state_s;
	smx_dec_state_s q;
	smx_dec_state_s next_q;
	logic [2:0] len_code;
	logic [2:0] lat_code;
	logic [4:0] wm_code;
	logic interleave;
	assign len_code = value_in[LEN_LSB +: 3];
	assign lat_code = value_in[LAT_LSB +: 3];
	assign wm_code = value_in[WM_LSB +: 5];
	assign interleave = value_in[ORDER_BIT];
	// ************************************************************
	// decode on each mode load
	// ************************************************************
	// reserved codes keep the previous setting of their own field; the other fields of the same load still apply
	always_comb
	begin
		next_q = q;
		next_q.rsvd_blen = 1'b0;
		next_q.rsvd_lat = 1'b0;
		next_q.rsvd_wmode = 1'b0;
		if (load_in)
		begin
			next_q.cfg.interleaved = interleave;
			if (len_code == LEN_1 || len_code == LEN_2 || len_code == LEN_4 || len_code == LEN_8)
				next_q.cfg.burst_words = 9'h001 << len_code;
			else if (len_code == LEN_FULL && !interleave)
				next_q.cfg.burst_words = WORDS_FULL;
			else
				next_q.rsvd_blen = 1'b1;
			if (lat_code == LAT_2 || lat_code == LAT_3)
				next_q.cfg.read_latency = lat_code[1:0];
			else
				next_q.rsvd_lat = 1'b1;
			if (wm_code == WM_BURST)
				next_q.cfg.single_write = 1'b0;
			else if (wm_code == WM_SINGLE)
				next_q.cfg.single_write = 1'b1;
			else
				next_q.rsvd_wmode = 1'b1;
		end
		next_q.cfg.write_words = next_q.cfg.single_write ? 9'h001 :
			next_q.cfg.burst_words;
	end
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			q <= '{cfg: '{burst_words: 9'h001, interleaved: 1'b0, read_latency: LAT_RESET,
				single_write: 1'b0, write_words: 9'h001}, rsvd_blen: 1'b0, rsvd_lat: 1'b0,
				rsvd_wmode: 1'b0};
		end
		else
			q <= next_q;
	end
	assign cfg_out = q.cfg;
	assign rsvd_blen_out = q.rsvd_blen;
	assign rsvd_lat_out = q.rsvd_lat;
	assign rsvd_wmode_out = q.rsvd_wmode;
	AST_FULL_PAGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		load_in && len_code == LEN_FULL |=> ($past(interleave) ? rsvd_blen_out :
		cfg_out.burst_words == WORDS_FULL))
		else $error("full page burst length decoded wrongly");
	AST_LATENCY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		load_in && lat_code == LAT_3 |=> cfg_out.read_latency == 2'h3 && !rsvd_lat_out)
		else $error("latency three not decoded");
	AST_SINGLE_WORD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		load_in && wm_code == WM_SINGLE |=> cfg_out.single_write && cfg_out.write_words == 9'h001)
		else $error("single write does not limit write to one word");
endmodule

//--- smx_self_refresh.sv
`timescale 1ns/10ps
module smx_self_refresh
	import smx_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic [2:0] coverage_in,
	input wire logic [1:0] rate_in,
	output logic refresh_pulse_out,
	output logic refresh_bank_out,
	output logic [10:0] refresh_row_out
);
	typedef struct packed
	{
		logic [15:0] div;
		logic [11:0] cnt;
		logic pulse;
		logic [11:0] addr;
	} smx_sref_state_s;
	smx_sref_state_s q;
	smx_sref_state_s next_q;
	logic [11:0] last;
	logic [15:0] period;
	// reserved coverage codes fall back to full coverage: refreshing too much is safe
	function automatic logic [11:0] smx_cover_mask(input logic [2:0] code);
		if (code == COVER_ONE)
			return 12'h7FF;
		else if (code == COVER_HALF)
			return 12'h3FF;
		else if (code == COVER_QUARTER)
			return 12'h1FF;
		else
			return 12'hFFF;
	endfunction
	assign last = smx_cover_mask(coverage_in);
	// cooler settings stretch the interval; code zero is the hottest-case rate
	assign period = REFRESH_BASE_CYCLES << rate_in;
	// ************************************************************
	// row scan
	// ************************************************************
	always_comb
	begin
		next_q = q;
		next_q.pulse = 1'b0;
		if (!enable_in)
		begin
			next_q.div = 16'h0000;
		end
		else if (q.div >= period - 16'h0001)
		begin
			next_q.div = 16'h0000;
			next_q.pulse = 1'b1;
			next_q.addr = q.cnt & last;
			next_q.cnt = ((q.cnt & last) == last) ? 12'h000 : (q.cnt & last) + 12'h001;
		end
		else
			next_q.div = q.div + 16'h0001;
	end
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
			q <= '{div: 16'h0000, cnt: 12'h000, pulse: 1'b0, addr: 12'h000};
		else
			q <= next_q;
	end
	assign refresh_pulse_out = q.pulse;
	assign refresh_bank_out = q.addr[11];
	assign refresh_row_out = q.addr[10:0];
	AST_HALF_BANK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		refresh_pulse_out && $past(coverage_in) == COVER_HALF
		|-> !refresh_bank_out && !refresh_row_out[10])
		else $error("half bank refresh left the lower half of bank 0");
	AST_QUARTER_BANK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		refresh_pulse_out && $past(coverage_in) == COVER_QUARTER
		|-> !refresh_bank_out && refresh_row_out[10:9] == 2'b00)
		else $error("quarter bank refresh left the lowest quarter of bank 0");
endmodule

//--- smx_ctrl_model.sv
`timescale 1ns/10ps
// ********
// controller stand-in issuing load commands
// ********
module smx_ctrl_model
	import smx_pkg::*;
(
	input wire logic clk_sys_in,
	output smx_pins_s pins_out,
	output logic banks_idle_out
);
	initial
	begin
		pins_out = PINS_IDLE;
		banks_idle_out = 1'h1;
	end
	// callers keep reserved bits legal unless a refusal is wanted
	task automatic load_cfg(input logic [11:0] v, input logic idle, input logic soon);
		@(posedge clk_sys_in);
		pins_out <= '{1'h0, 1'h0, 1'h0, 1'h0, v};
		@(posedge clk_sys_in);
		// soon: a refresh right after the load breaks the guard
		pins_out <= '{!soon, !soon, !soon, 1'h1, ~v};
		// busy status held over the sync delay of the load
		banks_idle_out <= idle;
		@(posedge clk_sys_in);
		// a refresh two cycles after a plain load is legal and must pass unflagged
		pins_out <= '{soon, soon, soon, 1'h1, ~v};
		@(posedge clk_sys_in);
		// deselected address shows the inverse, never a stale copy
		pins_out <= '{1'h1, 1'h1, 1'h1, 1'h1, ~v};
		repeat (3) @(posedge clk_sys_in);
		banks_idle_out <= 1'h1;
		// guard time before the next operation
		repeat (4) @(posedge clk_sys_in);
	endtask
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top
	import smx_pkg::*;
;
	typedef struct packed {logic [11:0] v; smx_cfg_s c;} smx_mrow_s;
	typedef struct packed {logic [11:0] v; logic [11:0] gap; logic [2:0] m;} smx_srow_s;
	typedef struct packed {logic [11:0] v; logic idle; logic soon; logic [7:0] e;} smx_erow_s;
	localparam smx_cfg_s CFG0 = '{9'h001, 1'h0, 2'h3, 1'h0, 9'h001};
	smx_mrow_s mrow [6] = '{
		'{12'h022, '{9'h004, 1'h0, 2'h2, 1'h0, 9'h004}},
		'{12'h033, '{9'h008, 1'h0, 2'h3, 1'h0, 9'h008}},
		'{12'h038, '{9'h001, 1'h1, 2'h3, 1'h0, 9'h001}},
		'{12'h221, '{9'h002, 1'h0, 2'h2, 1'h1, 9'h001}},
		'{12'h037, '{WORDS_FULL, 1'h0, 2'h3, 1'h0, WORDS_FULL}},
		'{12'h021, '{9'h002, 1'h0, 2'h2, 1'h0, 9'h002}}};
	logic [11:0] xv [4] = '{12'h820, 12'h80B, 12'h812, 12'h819};
	smx_srow_s srow [3] = '{'{12'h803, 12'h200, 3'h7}, '{12'h80A, 12'h400, 3'h6},
		'{12'h801, 12'h200, 3'h4}};
	smx_erow_s erow [8] = '{'{12'h034, 1'h1, 1'h0, 8'h02}, '{12'h03F, 1'h1, 1'h0, 8'h02},
		'{12'h012, 1'h1, 1'h0, 8'h04}, '{12'h422, 1'h1, 1'h0, 8'h01},
		'{12'h840, 1'h1, 1'h0, 8'h08}, '{12'h022, 1'h0, 1'h0, 8'h10},
		'{12'h022, 1'h1, 1'h1, 8'h20}, '{12'h805, 1'h1, 1'h0, 8'h40}};
	logic clk_sys_in = 1'h0;
	logic rst_in = 1'h1;
	logic awv = 1'h0;
	logic wv = 1'h0;
	logic bre = 1'h0;
	logic arv = 1'h0;
	logic rre = 1'h0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awr, wrd, bv, arr, rv, half, pulse, bank, idle;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdat, q;
	logic [10:0] row;
	smx_cfg_s cfg;
	smx_pins_s pins;
	int n_fail = 0;
	int n_compared = 0;
	int n;
	always #12.5 clk_sys_in = ~clk_sys_in;
	smx_ctrl_model model (.clk_sys_in(clk_sys_in), .pins_out(pins), .banks_idle_out(idle));
	smx_config_regs uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_pins_in(pins),
		.banks_idle_in(idle), .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa),
		.axi_wvalid_in(wv), .axi_wready_out(wrd), .axi_wdata_in(wd), .axi_wstrb_in(4'hF),
		.axi_bvalid_out(bv), .axi_bready_in(bre), .axi_bresp_out(bresp), .axi_arvalid_in(arv),
		.axi_arready_out(arr), .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rre),
		.axi_rdata_out(rdat), .axi_rresp_out(rresp), .cfg_out(cfg), .drive_half_out(half),
		.refresh_pulse_out(pulse), .refresh_bank_out(bank), .refresh_row_out(row));
	// ********
	// helpers
	// ********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// handshakes are sampled at the falling edge so ready decoding never races the bench
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] qo, output logic [1:0] ro);
		logic ha, hw, har, fin;
		fin = 1'h0;
		@(posedge clk_sys_in);
		awv <= w;
		wv <= w;
		bre <= w;
		arv <= !w;
		rre <= !w;
		awa <= a;
		ara <= a;
		wd <= d;
		while (!fin)
		begin
			@(negedge clk_sys_in);
			ha = awv && awr;
			hw = wv && wrd;
			har = arv && arr;
			fin = (bv && bre) || (rv && rre);
			qo = rdat;
			ro = w ? bresp : rresp;
			@(posedge clk_sys_in);
			if (ha) awv <= 1'h0;
			if (hw) wv <= 1'h0;
			if (har) arv <= 1'h0;
			if (fin) bre <= 1'h0;
			if (fin) rre <= 1'h0;
		end
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] qo);
		logic [1:0] ro;
		axi(1'h0, a, 32'h0, qo, ro);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] qo;
		logic [1:0] ro;
		axi(1'h1, a, d, qo, ro);
	endtask
	task automatic wait_pulse(output int k);
		k = 0;
		do
		begin
			@(negedge clk_sys_in);
			k++;
		end
		while (pulse !== 1'h1 && k < 3000);
	endtask
	task automatic chk_rst();
		@(negedge clk_sys_in);
		check({10'h000, cfg}, {10'h000, CFG0});
		check({31'h0, half}, 32'h0);
		reg_rd(REG_EXT, q);
		check(q, 32'h0);
	endtask
	task automatic note(input string s);
		$display("test %s finished", s);
	endtask
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ********
	// tests
	// ********
	initial
	begin
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		chk_rst();
		note("reset");
		foreach (mrow[i])
		begin
			model.load_cfg(mrow[i].v, 1'h1, 1'h0);
			check({10'h000, cfg}, {10'h000, mrow[i].c});
			reg_rd(REG_MODE, q);
			check(q, {20'h0, mrow[i].v});
		end
		note("mode");
		foreach (xv[i])
		begin
			model.load_cfg(xv[i], 1'h1, 1'h0);
			check({31'h0, half}, {31'h0, xv[i][5]});
			reg_rd(REG_EXT, q);
			check(q, {20'h0, xv[i]});
		end
		model.load_cfg(12'h022, 1'h1, 1'h0);
		reg_rd(REG_EXT, q);
		check(q, 32'h819);
		note("extended");
		reg_wr(REG_CTRL, 32'h1);
		foreach (srow[i])
		begin
			model.load_cfg(srow[i].v, 1'h1, 1'h0);
			wait_pulse(n);
			wait_pulse(n);
			check(n, {20'h0, srow[i].gap});
			check({29'h0, {bank, row[10:9]} & srow[i].m}, 32'h0);
		end
		reg_wr(REG_CTRL, 32'h0);
		wait_pulse(n);
		check(n, 32'hBB8);
		note("self refresh");
		foreach (erow[i])
		begin
			model.load_cfg(erow[i].v, erow[i].idle, erow[i].soon);
			if (i == 0) check({23'h0, cfg.burst_words}, 32'h4);
			reg_rd(REG_ERR, q);
			check(q, {24'h0, erow[i].e});
			reg_wr(REG_ERR, 32'h7F);
			reg_rd(REG_ERR, q);
			check(q, 32'h0);
		end
		note("refusals");
		axi(1'h0, 8'h40, 32'h0, q, r);
		check({q[29:0], r}, {30'h0, RESP_SLVERR});
		axi(1'h1, REG_MODE, 32'hFFF, q, r);
		check({30'h0, r}, {30'h0, RESP_OKAY});
		reg_rd(REG_MODE, q);
		check(q, 32'h022);
		note("bus");
		@(posedge clk_sys_in);
		rst_in <= 1'h1;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		chk_rst();
		note("second reset");
		report_and_stop();
	end
	// tests need about 7500 cycles; the margin covers slow bus answers
	initial
	begin
		repeat (30000) @(posedge clk_sys_in);
		n_fail++;
		report_and_stop();
	end
endmodule
